// ### hw/pci_reset_pkg.sv
// Purpose: Shared constants and types for the PCI reset coordination ends.
// Assumes: One 10 MHz clock for both ends.
// Notes: Counts are derived from times at the clock rate.

package pci_reset_pkg;

	// ----------------------------------------------------------------
	// Widths and layout
	// ----------------------------------------------------------------
	localparam int WINDOW_COUNT = 6;
	localparam int BOOT_WIDTH = 4;
	localparam int STATUS_WIDTH = 4;
	localparam logic [WINDOW_COUNT-1:0] WINDOWS_OFF = 6'h00;
	localparam logic [STATUS_WIDTH-1:0] STATUS_NONE = 4'h0;
	localparam logic [STATUS_WIDTH-1:0] STATUS_ALL = 4'hF;
	localparam logic [BOOT_WIDTH-1:0] BOOT_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Reset source indices
	// ----------------------------------------------------------------
	localparam int SRC_COUNT = 4;
	localparam int SRC_EXT = 0;
	localparam int SRC_GLOBAL = 1;
	localparam int SRC_BOOT = 2;
	localparam int SRC_POR = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYCLES =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HOLD_LAST = 4'(RESET_HOLD_CYCLES - 1);
	localparam logic [3:0] HOLD_ZERO = 4'h0;

	// ----------------------------------------------------------------
	// Disconnect sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEQ_RUN,
		SEQ_UNPARK,
		SEQ_STOP,
		SEQ_DISABLE,
		SEQ_ASSERT,
		SEQ_WAIT_OUT,
		SEQ_RELEASE,
		SEQ_RECONFIG
	} seq_state_t;

endpackage : pci_reset_pkg

// ### hw/pci_reset_if.sv
// Purpose: Reset pins and configuration path between device and system.
// Assumes: All signals are synchronous to the shared clock.
// Notes: Active low pins carry the _n suffix.
`timescale 1ns/1ps

interface pci_reset_if;
	import pci_reset_pkg::*;

	logic bus_reset_n;
	logic por_n;
	logic warm_reset_n;
	logic emu_reset;
	logic watchdog_reset;
	logic reset_released_out;
	logic psc_release;
	logic psc_assert;
	logic park_on_device;
	logic stop_transactions;
	logic master_active;
	logic cfg_write;
	logic [WINDOW_COUNT-1:0] cfg_window_enable;
	logic cfg_bus_master;
	logic cfg_memory_space;
	logic cfg_done;
	logic [STATUS_WIDTH-1:0] status_clear;
	logic [BOOT_WIDTH-1:0] boot_pins;

	modport dev (
		input bus_reset_n, por_n, warm_reset_n, emu_reset, watchdog_reset,
		input psc_release, psc_assert, park_on_device, stop_transactions,
		input cfg_write, cfg_window_enable, cfg_bus_master,
		input cfg_memory_space, cfg_done, status_clear, boot_pins,
		output reset_released_out, master_active
	);

	modport sys (
		output bus_reset_n, por_n, warm_reset_n, emu_reset, watchdog_reset,
		output psc_release, psc_assert, park_on_device, stop_transactions,
		output cfg_write, cfg_window_enable, cfg_bus_master,
		output cfg_memory_space, cfg_done, status_clear, boot_pins,
		input reset_released_out, master_active
	);

endinterface : pci_reset_if

// ### hw/pci_reset_device.sv
// Purpose: Reset coordination inside the device's PCI module.
// Assumes: Link pins are synchronous to clk; resets enter asynchronously.
// Notes: Release of every reset source is resynchronised to clk.
//
// Contract
// - Bus reset initialises PCI registers and outputs.
// - Power-on reset also asserts external PCI reset.
// - Controller asserts internal reset after global reset.
// - Internal reset holds until controller release.
// - Warm and emulation resets spare emulation logic.
// - Board ties warm reset to bus reset.
// - Release internal only after bus reset asserted.
// - Software never re-asserts internal reset afterwards.
// - Watchdog chip reset unused while PCI active.
// - Internal and external resets asserted together.
// - Boot pins latched on power-on or warm release.
// - Global reset never resets other bus agents.
// - PCI outputs high impedance during any reset.
// - Agent unparks bus and stops transactions first.
// - Agent clears windows, master and memory enables.
// - Agent asserts both resets, waits, reconfigures.
// - No access acknowledged until module reconfigured.
// - System tolerates master aborts before reconfiguration.
// - Avoid resetting during an ongoing transaction.
// - Enables act through module; status cleared by one.
`timescale 1ns/1ps

module pci_reset_device (
	input wire logic clk,
	input wire logic reset,
	pci_reset_if.dev link,
	input wire logic master_req,
	input wire logic [pci_reset_pkg::STATUS_WIDTH-1:0] status_event,
	output logic module_reset,
	output logic chip_reset,
	output logic emu_logic_reset,
	output logic pci_oe,
	output logic drive_idle,
	output logic access_ack_en,
	output logic [pci_reset_pkg::WINDOW_COUNT-1:0] slave_window_enable,
	output logic bus_master_enable,
	output logic memory_space_enable,
	output logic [pci_reset_pkg::STATUS_WIDTH-1:0] status_bits,
	output logic [pci_reset_pkg::BOOT_WIDTH-1:0] boot_config
);
	import pci_reset_pkg::*;

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	logic [SRC_COUNT-1:0] raw_reset;
	logic [SRC_COUNT-1:0] sync_reset;
	logic ext_rst;
	logic global_rst;
	logic boot_rst;
	logic por_rst;
	logic pci_rst;

	assign raw_reset[SRC_EXT] = reset | ~link.bus_reset_n | ~link.por_n;

	// Warm and emulation reset the chip.
	assign raw_reset[SRC_GLOBAL] = reset | ~link.por_n
		| ~link.warm_reset_n | link.emu_reset | link.watchdog_reset;

	// Boot latch follows power-on or warm.
	assign raw_reset[SRC_BOOT] = reset | ~link.por_n | ~link.warm_reset_n;

	assign raw_reset[SRC_POR] = reset | ~link.por_n;

	// ----------------------------------------------------------------
	// Reset synchronisers
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < SRC_COUNT; i++)
		begin : g_sync
			logic stage1;
			logic stage2;

			always_ff @(posedge clk or posedge raw_reset[i])
			begin
				if (raw_reset[i])
				begin
					stage1 <= 1'b1;
					stage2 <= 1'b1;
				end
				else
				begin
					stage1 <= 1'b0;
					stage2 <= stage1;
				end
			end

			assign sync_reset[i] = stage2;
		end
	endgenerate

	assign ext_rst = sync_reset[SRC_EXT];
	assign global_rst = sync_reset[SRC_GLOBAL];
	assign boot_rst = sync_reset[SRC_BOOT];
	assign por_rst = sync_reset[SRC_POR];

	// ----------------------------------------------------------------
	// Module state
	// ----------------------------------------------------------------
	logic int_reset;
	logic configured;
	logic boot_prev;
	logic [WINDOW_COUNT-1:0] windows;
	logic bme;
	logic mse;
	logic [STATUS_WIDTH-1:0] status;
	logic [BOOT_WIDTH-1:0] boot;
	logic next_int_reset;
	logic next_configured;
	logic next_boot_prev;
	logic [WINDOW_COUNT-1:0] next_windows;
	logic next_bme;
	logic next_mse;
	logic [STATUS_WIDTH-1:0] next_status;
	logic [BOOT_WIDTH-1:0] next_boot;

	// The PCI logic stays in reset while either reset is active.
	assign pci_rst = ext_rst | int_reset;

	always_comb
	begin
		next_int_reset = int_reset;
		next_configured = configured;
		next_boot_prev = boot_rst;
		next_windows = windows;
		next_bme = bme;
		next_mse = mse;
		next_status = status;
		next_boot = boot;

		if (global_rst)
		begin
			next_int_reset = 1'b1;
		end
		else if (link.psc_assert)
		begin
			next_int_reset = 1'b1;
		end
		else if (link.psc_release)
		begin
			next_int_reset = 1'b0;
		end

		if (pci_rst)
		begin
			next_configured = 1'b0;
			next_windows = WINDOWS_OFF;
			next_bme = 1'b0;
			next_mse = 1'b0;
			next_status = STATUS_NONE;
		end
		else
		begin
			if (link.cfg_write)
			begin
				next_windows = link.cfg_window_enable;
				next_bme = link.cfg_bus_master;
				next_mse = link.cfg_memory_space;
			end
			if (link.cfg_done)
			begin
				next_configured = 1'b1;
			end
			next_status = (status & ~link.status_clear) | status_event;
		end

		if (boot_prev && !boot_rst)
		begin
			next_boot = link.boot_pins;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			int_reset <= 1'b1;
			configured <= 1'b0;
			boot_prev <= 1'b1;
			windows <= WINDOWS_OFF;
			bme <= 1'b0;
			mse <= 1'b0;
			status <= STATUS_NONE;
			boot <= BOOT_RESET;
		end
		else
		begin
			int_reset <= next_int_reset;
			configured <= next_configured;
			boot_prev <= next_boot_prev;
			windows <= next_windows;
			bme <= next_bme;
			mse <= next_mse;
			status <= next_status;
			boot <= next_boot;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Reset only local logic; no bus reset driven.
	assign chip_reset = global_rst;
	assign emu_logic_reset = por_rst;
	assign module_reset = pci_rst;
	assign link.reset_released_out = ~global_rst;

	assign pci_oe = ~(pci_rst | global_rst);
	assign drive_idle = pci_oe & link.park_on_device;

	assign access_ack_en = pci_oe & configured & ((|windows) | mse);

	assign link.master_active = master_req & bme & pci_oe
		& ~link.stop_transactions;

	assign slave_window_enable = windows;
	assign bus_master_enable = bme;
	assign memory_space_enable = mse;
	assign status_bits = status;
	assign boot_config = boot;

endmodule : pci_reset_device

// ### hw/pci_reset_system.sv
// Purpose: Board reset sources and disconnect sequencer for the device.
// Assumes: Link pins are synchronous to clk.
// Notes: Warm reset and bus reset share one driver.
`timescale 1ns/1ps

module pci_reset_system (
	input wire logic clk,
	input wire logic reset,
	pci_reset_if.sys link,
	input wire logic reset_req,
	input wire logic por_req,
	input wire logic watchdog_expired,
	input wire logic [pci_reset_pkg::BOOT_WIDTH-1:0] boot_straps,
	input wire logic [pci_reset_pkg::WINDOW_COUNT-1:0] cfg_windows,
	input wire logic cfg_master,
	input wire logic cfg_memory,
	output logic busy,
	output logic reset_request_gpio
);
	import pci_reset_pkg::*;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	seq_state_t state;
	seq_state_t next_state;
	logic [3:0] hold_cnt;
	logic [3:0] next_hold_cnt;
	logic rst_pin;
	logic next_rst_pin;
	logic por_pin;
	logic next_por_pin;
	logic park;
	logic next_park;
	logic stop;
	logic next_stop;
	logic rel;
	logic next_rel;
	logic wr;
	logic next_wr;
	logic done;
	logic next_done;
	logic [WINDOW_COUNT-1:0] win;
	logic [WINDOW_COUNT-1:0] next_win;
	logic bm;
	logic next_bm;
	logic ms;
	logic next_ms;
	logic gpio;
	logic next_gpio;

	always_comb
	begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		next_rst_pin = 1'b0;
		next_por_pin = por_req;
		next_park = park;
		next_stop = stop;
		next_rel = 1'b0;
		next_wr = 1'b0;
		next_done = 1'b0;
		next_win = win;
		next_bm = bm;
		next_ms = ms;
		next_gpio = gpio;

		if (watchdog_expired)
		begin
			next_gpio = ~gpio;
		end

		unique case (state)
			SEQ_RUN:
			begin
				if (reset_req)
				begin
					next_state = SEQ_UNPARK;
				end
			end
			SEQ_UNPARK:
			begin
				next_park = 1'b0;
				next_state = SEQ_STOP;
			end
			SEQ_STOP:
			begin
				next_stop = 1'b1;
				if (stop && !link.master_active)
				begin
					next_state = SEQ_DISABLE;
				end
			end
			SEQ_DISABLE:
			begin
				next_wr = 1'b1;
				next_win = WINDOWS_OFF;
				next_bm = 1'b0;
				next_ms = 1'b0;
				next_hold_cnt = HOLD_LAST;
				// A pin held since reset stays asserted.
				next_rst_pin = rst_pin;
				next_state = SEQ_ASSERT;
			end
			SEQ_ASSERT:
			begin
				next_rst_pin = 1'b1;
				if (rst_pin && hold_cnt == HOLD_ZERO)
				begin
					next_rst_pin = 1'b0;
					next_state = SEQ_WAIT_OUT;
				end
				else if (rst_pin)
				begin
					next_hold_cnt = hold_cnt - 4'h1;
				end
			end
			SEQ_WAIT_OUT:
			begin
				if (!rst_pin && link.reset_released_out)
				begin
					next_state = SEQ_RELEASE;
				end
			end
			SEQ_RELEASE:
			begin
				next_rel = 1'b1;
				next_state = SEQ_RECONFIG;
			end
			SEQ_RECONFIG:
			begin
				next_wr = 1'b1;
				next_done = 1'b1;
				next_win = cfg_windows;
				next_bm = cfg_master;
				next_ms = cfg_memory;
				next_park = 1'b1;
				next_stop = 1'b0;
				next_state = SEQ_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= SEQ_DISABLE;
			hold_cnt <= HOLD_ZERO;
			rst_pin <= 1'b1;
			por_pin <= 1'b1;
			park <= 1'b0;
			stop <= 1'b1;
			rel <= 1'b0;
			wr <= 1'b0;
			done <= 1'b0;
			win <= WINDOWS_OFF;
			bm <= 1'b0;
			ms <= 1'b0;
			gpio <= 1'b0;
		end
		else
		begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			rst_pin <= next_rst_pin;
			por_pin <= next_por_pin;
			park <= next_park;
			stop <= next_stop;
			rel <= next_rel;
			wr <= next_wr;
			done <= next_done;
			win <= next_win;
			bm <= next_bm;
			ms <= next_ms;
			gpio <= next_gpio;
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	// Warm reset tied to bus reset.
	assign link.bus_reset_n = ~rst_pin;
	assign link.warm_reset_n = ~rst_pin;
	assign link.por_n = ~por_pin;
	// No watchdog or emulation chip reset.
	assign link.emu_reset = 1'b0;
	assign link.watchdog_reset = 1'b0;
	assign link.psc_assert = 1'b0;
	assign link.psc_release = rel;
	assign link.park_on_device = park;
	assign link.stop_transactions = stop;
	assign link.cfg_write = wr;
	assign link.cfg_window_enable = win;
	assign link.cfg_bus_master = bm;
	assign link.cfg_memory_space = ms;
	assign link.cfg_done = done;
	assign link.status_clear = done ? STATUS_ALL : STATUS_NONE;
	assign link.boot_pins = boot_straps;
	assign busy = (state != SEQ_RUN);
	assign reset_request_gpio = gpio;

endmodule : pci_reset_system

// ### bench/pci_reset_sva.sv
// Purpose: Concurrent checks on the link between system and device ends.
// Assumes: One clock; reset is asynchronous and active high.
// Notes: Watches only the interface pins.
`timescale 1ns/1ps

module pci_reset_sva
	import pci_reset_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_reset_n,
	input wire logic por_n,
	input wire logic warm_reset_n,
	input wire logic emu_reset,
	input wire logic watchdog_reset,
	input wire logic reset_released_out,
	input wire logic psc_release,
	input wire logic psc_assert,
	input wire logic park_on_device,
	input wire logic stop_transactions,
	input wire logic cfg_write,
	input wire logic [WINDOW_COUNT-1:0] cfg_window_enable,
	input wire logic cfg_bus_master,
	input wire logic cfg_memory_space,
	input wire logic cfg_done,
	input wire logic [STATUS_WIDTH-1:0] status_clear
);
	// ----------------------------------------------------------------
	// Bus reset low-time counter
	// ----------------------------------------------------------------
	logic [3:0] low_count;
	logic [3:0] next_low_count;

	always_comb
	begin
		if (bus_reset_n)
			next_low_count = 4'h0;
		else if (low_count == 4'hF)
			next_low_count = low_count;
		else
			next_low_count = low_count + 4'h1;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			low_count <= 4'hF;
		else
			low_count <= next_low_count;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	pins_tied_a: assert property (
		bus_reset_n == warm_reset_n) else $error("Warm and bus reset differ.");
	chip_sources_idle_a: assert property (
		!emu_reset && !watchdog_reset) else $error("Chip reset source used.");
	no_reassert_a: assert property (
		!psc_assert) else $error("Internal reset asserted again.");
	released_low_a: assert property (
		(!warm_reset_n || !por_n) |-> !reset_released_out)
		else $error("Released output high during reset.");
	release_seen_a: assert property (
		$rose(warm_reset_n) && por_n |-> ##[1:3] reset_released_out)
		else $error("Released output did not rise.");
	psc_after_bus_a: assert property (
		psc_release |-> reset_released_out && bus_reset_n)
		else $error("Internal release before bus reset cycle.");
	stop_after_unpark_a: assert property (
		$rose(stop_transactions) |-> !park_on_device)
		else $error("Transactions stopped while parked.");
	disable_zero_a: assert property (
		cfg_write && stop_transactions && !park_on_device |->
		cfg_window_enable == WINDOWS_OFF && !cfg_bus_master &&
		!cfg_memory_space) else $error("Disable write not all zero.");
	hold_time_a: assert property (
		$rose(bus_reset_n) |-> low_count >= 4'(RESET_HOLD_CYCLES))
		else $error("Bus reset held too briefly.");
	done_clears_a: assert property (
		cfg_done |-> status_clear == STATUS_ALL)
		else $error("Status not cleared at reconfiguration.");

	cover property ($rose(reset_released_out));
	cover property (psc_release);
	cover property (cfg_done);
	cover property ($fell(park_on_device));

endmodule : pci_reset_sva

// ### bench/tb_top.sv
// Purpose: Self-checking bench joining device and system ends.
// Assumes: 10 MHz clock; reset held for five cycles.
// Notes: Random configuration values come from a fixed seed.
`timescale 1ns/1ps

module tb_top;
	import pci_reset_pkg::*;

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic master_req = 1'b1;
	logic [STATUS_WIDTH-1:0] status_event = 4'h0;
	logic reset_req = 1'b0;
	logic por_req = 1'b0;
	logic watchdog_expired = 1'b0;
	logic [BOOT_WIDTH-1:0] boot_straps = 4'h9;
	logic [WINDOW_COUNT-1:0] cfg_windows = 6'h15;
	logic cfg_master = 1'b1;
	logic cfg_memory = 1'b1;
	logic module_reset, chip_reset, emu_logic_reset, pci_oe, drive_idle;
	logic access_ack_en, bus_master_enable, memory_space_enable;
	logic [WINDOW_COUNT-1:0] slave_window_enable;
	logic [STATUS_WIDTH-1:0] status_bits;
	logic [BOOT_WIDTH-1:0] boot_config;
	logic [BOOT_WIDTH-1:0] old_boot;
	logic busy, reset_request_gpio, old_gpio;
	logic [3:0] ev1, ev2;
	int errors = 0;
	int check_count = 0;

	pci_reset_if link();

	pci_reset_device i_pci_reset_device (
		.clk(clk),
		.reset(reset),
		.link(link),
		.master_req(master_req),
		.status_event(status_event),
		.module_reset(module_reset),
		.chip_reset(chip_reset),
		.emu_logic_reset(emu_logic_reset),
		.pci_oe(pci_oe),
		.drive_idle(drive_idle),
		.access_ack_en(access_ack_en),
		.slave_window_enable(slave_window_enable),
		.bus_master_enable(bus_master_enable),
		.memory_space_enable(memory_space_enable),
		.status_bits(status_bits),
		.boot_config(boot_config)
	);

	pci_reset_system i_pci_reset_system (
		.clk(clk),
		.reset(reset),
		.link(link),
		.reset_req(reset_req),
		.por_req(por_req),
		.watchdog_expired(watchdog_expired),
		.boot_straps(boot_straps),
		.cfg_windows(cfg_windows),
		.cfg_master(cfg_master),
		.cfg_memory(cfg_memory),
		.busy(busy),
		.reset_request_gpio(reset_request_gpio)
	);

	pci_reset_sva i_pci_reset_sva (
		.clk(clk),
		.reset(reset),
		.bus_reset_n(link.bus_reset_n),
		.por_n(link.por_n),
		.warm_reset_n(link.warm_reset_n),
		.emu_reset(link.emu_reset),
		.watchdog_reset(link.watchdog_reset),
		.reset_released_out(link.reset_released_out),
		.psc_release(link.psc_release),
		.psc_assert(link.psc_assert),
		.park_on_device(link.park_on_device),
		.stop_transactions(link.stop_transactions),
		.cfg_write(link.cfg_write),
		.cfg_window_enable(link.cfg_window_enable),
		.cfg_bus_master(link.cfg_bus_master),
		.cfg_memory_space(link.cfg_memory_space),
		.cfg_done(link.cfg_done),
		.status_clear(link.status_clear)
	);

	initial
	begin
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task close_out;
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	function automatic logic [7:0] exp_ack(input logic [5:0] w, input logic m);
		return {7'h00, (|w) | m};
	endfunction : exp_ack

	task wait_sig(input int sel, input logic level);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while ((sel ? link.bus_reset_n : busy) !== level && n < 300);
		if ((sel ? link.bus_reset_n : busy) !== level)
		begin
			check(sel ? "bus_reset_n" : "busy", 8'hFF, {7'h00, level});
			close_out();
		end
	endtask : wait_sig

	task check_up(input string name);
		@(negedge clk);
		check("module_reset", module_reset, 8'h00);
		check("windows", slave_window_enable, cfg_windows);
		check("bus_master", bus_master_enable, cfg_master);
		check("memory", memory_space_enable, cfg_memory);
		check("ack_en", access_ack_en, exp_ack(cfg_windows, cfg_memory));
		check("boot_config", boot_config, boot_straps);
		check("status", status_bits, STATUS_NONE);
		check("master_active", link.master_active, cfg_master);
		check("drive_idle", drive_idle, 8'h01);
		$display("Test %s done", name);
	endtask : check_up

	task run_seq(input string name);
		@(posedge clk);
		reset_req <= 1'b1;
		wait_sig(0, 1'b1);
		@(posedge clk);
		reset_req <= 1'b0;
		wait_sig(1, 1'b0);
		@(negedge clk);
		check("chip_reset", chip_reset, 8'h01);
		check("emu_reset", emu_logic_reset, 8'h00);
		check("module_reset", module_reset, 8'h01);
		check("pci_oe", pci_oe, 8'h00);
		check("ack_en", access_ack_en, 8'h00);
		check("windows", slave_window_enable, WINDOWS_OFF);
		check("master_active", link.master_active, 8'h00);
		wait_sig(0, 1'b0);
		check_up(name);
	endtask : run_seq

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(28180));
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		wait_sig(0, 1'b0);
		check_up("power_up");
		ev1 = 4'($urandom);
		ev2 = 4'($urandom);
		@(posedge clk);
		status_event <= ev1;
		@(posedge clk);
		status_event <= ev2;
		@(posedge clk);
		status_event <= 4'h0;
		@(negedge clk);
		check("status", status_bits, ev1 | ev2);
		$display("Test status done");
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			old_boot = boot_config;
			boot_straps <= 4'($urandom);
			cfg_windows <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
			cfg_memory <= (i == 0) ? 1'b0 : 1'($urandom);
			cfg_master <= (i == 1) ? 1'b0 : 1'($urandom);
			repeat (3) @(negedge clk);
			check("boot_hold", boot_config, old_boot);
			run_seq("disconnect");
		end
		@(posedge clk);
		old_gpio = reset_request_gpio;
		watchdog_expired <= 1'b1;
		@(posedge clk);
		watchdog_expired <= 1'b0;
		repeat (2) @(negedge clk);
		check("gpio", reset_request_gpio, {7'h00, ~old_gpio});
		check("chip_reset", chip_reset, 8'h00);
		$display("Test watchdog done");
		@(posedge clk);
		por_req <= 1'b1;
		boot_straps <= 4'($urandom);
		repeat (3) @(negedge clk);
		check("chip_reset", chip_reset, 8'h01);
		check("emu_reset", emu_logic_reset, 8'h01);
		check("module_reset", module_reset, 8'h01);
		check("pci_oe", pci_oe, 8'h00);
		check("released", link.reset_released_out, 8'h00);
		@(posedge clk);
		por_req <= 1'b0;
		repeat (6) @(negedge clk);
		check("released", link.reset_released_out, 8'h01);
		check("module_reset", module_reset, 8'h01);
		check("ack_en", access_ack_en, 8'h00);
		check("abort_idle", drive_idle, 8'h00);
		check("boot_config", boot_config, boot_straps);
		run_seq("power_on");
		close_out();
	end

endmodule : tb_top
